// >>> hw/dler_top.sv
/*
  diagnostic LED error reporter: classifies fault codes, keeps category
  flags and the last code, issues error-log records and drives the error,
  run and battery LEDs in their blink patterns.
  assumes all inputs synchronous to ref_clk and a register master that
  never overlaps read and write strobes.
*/
// Chosen here: the plain strobed port and the address map.
// Behaviour
// - error LED blinks with 0.2 s period while 24 V supply is abnormal and no upgrade pattern or card work shows
// - abnormal supply reports 002A, sets supply flag, writes a log record
// - remote, extension, heartbeat faults blink error LED 1 s on per 3 s while no upgrade, card work or abnormal supply shows
// - remote connection loss reports 1500, sets remote flag, logs it
// - remote module errors 1502 to 150F set remote flag and log
// - extension module errors 1800 to 180F set extension flag and log
// - servo heartbeat codes 1900 to 191C carry node number, log, set only heartbeat_seen
// - battery low: indicator steady on unless clock failure, code 0027, flag set, no log
// - option hides battery-low indication, indication shown after reset
// - clock failure blinks indicator every 0.5 s, code 0026, flag, log
// - firmware upgrade blinks run and error together every 0.5 s
// - failed previous upgrade shows that pattern right from power-up
// - memory card operations blink run and error alternately every 0.5 s while no upgrade pattern shows
// - 0011, 0012, 002D set access check flag and log
// - retained memory codes 0050-0052, 0054-0056, 0059 set latched memory flag and log
// - 005D, 005E, 0063 set memory card flag and log
`timescale 1ns/1ps
`default_nettype none
`include "dler_map.svh"

module dler_top
  import dler_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DLER_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [15:0] reg_rdata,
  input wire dler_fault_t fault_in,
  input wire logic supply_abnormal,
  input wire logic battery_low,
  input wire logic rtc_fail,
  input wire logic fw_upgrade_active,
  input wire logic fw_upgrade_failed,
  input wire logic card_op_active,
  input wire logic run_state,
  output logic error_led,
  output logic run_led,
  output logic battery_indicator_led,
  output dler_log_t log_rec,
  output logic [15:0] err_code,
  output dler_flags_t flags
);

  // code classifier, one flag bit per category
  function automatic dler_flags_t classify(input logic [15:0] c);
    dler_flags_t f;
    f = '0;
    f.supply_fault_flag = (c == `DLER_CODE_SUPPLY);
    f.remote_module_fault_flag = (c == `DLER_CODE_REMOTE_LOST) ||
      (c >= `DLER_CODE_REMOTE_LO && c <= `DLER_CODE_REMOTE_HI);
    f.extension_module_fault_flag = (c >= `DLER_CODE_EXT_LO && c <= `DLER_CODE_EXT_HI);
    f.heartbeat_seen = (c >= `DLER_CODE_HB_LO && c <= `DLER_CODE_HB_HI);
    f.battery_low_flag = (c == `DLER_CODE_BATT);
    f.clock_fault_flag = (c == `DLER_CODE_RTC);
    f.access_check_flag = (c == `DLER_CODE_BAD_ID) || (c == `DLER_CODE_BAD_PW) ||
      (c == `DLER_CODE_PW_LIMIT);
    f.latched_memory_fault_flag = (c == `DLER_CODE_LAT_0) || (c == `DLER_CODE_LAT_1) ||
      (c == `DLER_CODE_LAT_2) || (c == `DLER_CODE_LAT_4) || (c == `DLER_CODE_LAT_5) ||
      (c == `DLER_CODE_LAT_6) || (c == `DLER_CODE_LAT_9);
    f.memory_card_flag = (c == `DLER_CODE_NO_CARD) || (c == `DLER_CODE_CARD_INIT) ||
      (c == `DLER_CODE_CARD_WR);
    return f;
  endfunction

  logic [`DLER_BASE_W-1:0] base_cnt_q;
  logic [`DLER_TICK_W-1:0] tick_cnt_q;
  logic supply_prev_q, rtc_prev_q, batt_prev_q;
  logic pend_sup_q, pend_rtc_q, pend_bat_q;
  logic batt_show_q, strap_done_q, fw_fail_q;
  logic error_led_q, run_led_q, batt_led_q;
  logic [15:0] err_code_q, rdata_q;
  dler_log_t log_q;
  dler_flags_t flags_q;

  // timebase: 0.1 s ticks counted 0..29, so every pattern shares one phase
  wire base_wrap = (base_cnt_q == `DLER_BASE_W'(TICK_CYCLES - 1));
  wire tick_wrap = (tick_cnt_q == `DLER_TICK_W'(`DLER_SLOW_TICKS - 1));
  wire [`DLER_TICK_W-1:0] fast_idx = tick_cnt_q / `DLER_TICK_W'(`DLER_FAST_TICKS);
  wire [`DLER_TICK_W-1:0] half_idx = tick_cnt_q / `DLER_TICK_W'(`DLER_HALF_TICKS);
  wire fast_ph = fast_idx[0];
  wire half_ph = half_idx[0];
  wire slow_on = (tick_cnt_q < `DLER_TICK_W'(`DLER_SLOW_ON_TICKS));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      base_cnt_q <= '0;
      tick_cnt_q <= '0;
    end else if (base_wrap) begin
      base_cnt_q <= '0;
      tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + `DLER_TICK_W'(1);
    end else begin
      base_cnt_q <= base_cnt_q + `DLER_BASE_W'(1);
    end
  end

  // register decode
  wire wr_ctrl = reg_wr_stb && (reg_addr == `DLER_REG_CTRL);
  wire wr_flags = reg_wr_stb && (reg_addr == `DLER_REG_FLAGS);
  wire fw_clr = wr_ctrl && reg_wdata[`DLER_CTRL_FW_CLR_BIT];
  wire dler_flags_t clr_mask = wr_flags ? dler_flags_t'(reg_wdata[`DLER_FLAGS_W-1:0]) : '0;

  // level inputs raise pending reports on their rising edge
  wire batt_shown = battery_low && batt_show_q;
  wire sup_rise = supply_abnormal && !supply_prev_q;
  wire rtc_rise = rtc_fail && !rtc_prev_q;
  wire bat_rise = batt_shown && !batt_prev_q;

  // an outside fault report wins the cycle; pending level faults drain after
  wire dler_flags_t ev_cls = classify(fault_in.code);
  wire ev_ok = fault_in.valid && (ev_cls != '0);
  wire take_sup = !ev_ok && pend_sup_q;
  wire take_rtc = !ev_ok && !pend_sup_q && pend_rtc_q;
  wire take_bat = !ev_ok && !pend_sup_q && !pend_rtc_q && pend_bat_q;
  wire rep_valid = ev_ok || take_sup || take_rtc || take_bat;
  wire [15:0] rep_code = ev_ok ? fault_in.code :
    take_sup ? `DLER_CODE_SUPPLY :
    take_rtc ? `DLER_CODE_RTC :
    `DLER_CODE_BATT;
  wire dler_flags_t rep_cls = rep_valid ? classify(rep_code) : '0;
  wire rep_log = rep_valid && !rep_cls.battery_low_flag;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      supply_prev_q <= 1'b0;
      rtc_prev_q <= 1'b0;
      batt_prev_q <= 1'b0;
      pend_sup_q <= 1'b0;
      pend_rtc_q <= 1'b0;
      pend_bat_q <= 1'b0;
    end else begin
      supply_prev_q <= supply_abnormal;
      rtc_prev_q <= rtc_fail;
      batt_prev_q <= batt_shown;
      pend_sup_q <= (pend_sup_q && !take_sup) || sup_rise;
      pend_rtc_q <= (pend_rtc_q && !take_rtc) || rtc_rise;
      pend_bat_q <= (pend_bat_q && !take_bat) || bat_rise;
    end
  end

  // flags: a new report beats a clear written in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_q <= '0;
      err_code_q <= 16'h0000;
      log_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr_mask) | rep_cls;
      err_code_q <= rep_valid ? rep_code : err_code_q;
      log_q.valid <= rep_log;
      log_q.code <= rep_code;
    end
  end

  // control bits; the upgrade-failed strap is caught in the first cycle after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      batt_show_q <= `DLER_CTRL_BATT_SHOW_RST;
      strap_done_q <= 1'b0;
      fw_fail_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (wr_ctrl) begin
        batt_show_q <= reg_wdata[`DLER_CTRL_BATT_SHOW_BIT];
      end
      if (!strap_done_q) begin
        fw_fail_q <= fw_upgrade_failed;
      end else if (fw_clr) begin
        fw_fail_q <= 1'b0;
      end
    end
  end

  // pattern choice: upgrade over card work over supply over module faults
  wire slow_cause = flags_q.remote_module_fault_flag || flags_q.extension_module_fault_flag ||
    flags_q.heartbeat_seen;
  wire dler_mode_t led_mode = (fw_upgrade_active || fw_fail_q) ? DLER_M_FW :
    card_op_active ? DLER_M_CARD :
    supply_abnormal ? DLER_M_SUPPLY :
    slow_cause ? DLER_M_SLOW : DLER_M_NONE;

  logic err_d, run_d;

  always_comb begin
    err_d = 1'b0;
    run_d = run_state;
    case (led_mode)
      DLER_M_FW: begin
        err_d = half_ph;
        run_d = half_ph;
      end
      DLER_M_CARD: begin
        err_d = half_ph;
        run_d = !half_ph;
      end
      DLER_M_SUPPLY: err_d = fast_ph;
      DLER_M_SLOW: err_d = slow_on;
      default: err_d = 1'b0;
    endcase
  end

  // clock failure blink hides the steady battery light
  wire batt_d = rtc_fail ? half_ph : batt_shown;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      error_led_q <= 1'b0;
      run_led_q <= 1'b0;
      batt_led_q <= 1'b0;
    end else begin
      error_led_q <= err_d;
      run_led_q <= run_d;
      batt_led_q <= batt_d;
    end
  end

  // read mux; unmapped offsets read zero
  wire [15:0] status_w = {9'h000, fw_fail_q, rtc_fail, battery_low, supply_abnormal,
    batt_led_q, run_led_q, error_led_q};
  wire [15:0] rd_mux = (reg_addr == `DLER_REG_CTRL) ? {15'h0000, batt_show_q} :
    (reg_addr == `DLER_REG_FLAGS) ? {7'h00, flags_q} :
    (reg_addr == `DLER_REG_CODE) ? err_code_q :
    (reg_addr == `DLER_REG_STATUS) ? status_w : 16'h0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_stb ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign error_led = error_led_q;
  assign run_led = run_led_q;
  assign battery_indicator_led = batt_led_q;
  assign log_rec = log_q;
  assign err_code = err_code_q;
  assign flags = flags_q;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mode_held(dler_mode_t m);
    (led_mode == m) [*2];
  endsequence

  sequence s_report(logic [15:0] c);
    fault_in.valid && fault_in.code == c;
  endsequence

  AST_FAST_BLINK: assert property (s_mode_held(DLER_M_SUPPLY) ##0 $changed(tick_cnt_q)
    |=> $changed(error_led_q))
    else $error("supply blink did not toggle on tick");
  AST_SUPPLY_REPORT: assert property (take_sup |=> log_q.valid && log_q.code == 16'h002A
    && flags_q.supply_fault_flag)
    else $error("supply fault not reported");
  AST_SLOW_ON: assert property (led_mode == DLER_M_SLOW && tick_cnt_q < 5'h0A |=> error_led_q)
    else $error("slow blink lit window wrong");
  AST_SLOW_OFF: assert property (led_mode == DLER_M_SLOW && tick_cnt_q >= 5'h0A |=> !error_led_q)
    else $error("slow blink dark window wrong");
  AST_REMOTE_LOST: assert property (s_report(16'h1500) |=> flags_q.remote_module_fault_flag && log_q.valid)
    else $error("remote loss not flagged");
  AST_REMOTE_ERR: assert property (s_report(16'h150F) |=> flags_q.remote_module_fault_flag
    && log_q.code == 16'h150F)
    else $error("remote error not flagged");
  AST_EXT_ERR: assert property (s_report(16'h1800) |=> flags_q.extension_module_fault_flag && log_q.valid)
    else $error("extension error not flagged");
  AST_HEARTBEAT: assert property (s_report(16'h191C) && flags_q == '0 |=> log_q.valid
    && flags_q.heartbeat_seen && flags_q[7:0] == 8'h00)
    else $error("heartbeat report wrong");
  AST_BATT_NO_LOG: assert property (take_bat |=> !log_q.valid && err_code_q == 16'h0027
    && flags_q.battery_low_flag)
    else $error("battery low logged or not flagged");
  AST_BATT_HIDE: assert property (!batt_show_q && !rtc_fail |=> !batt_led_q)
    else $error("hidden battery indication shown");
  AST_RTC_BLINK: assert property (rtc_fail [*2] ##0 $changed(half_ph) |=> $changed(batt_led_q))
    else $error("clock fault blink did not toggle");
  AST_FW_SYNC: assert property (led_mode == DLER_M_FW |=> run_led_q == error_led_q)
    else $error("upgrade blink not in phase");
  AST_FW_BOOT: assert property (fw_fail_q && !fw_clr |=> fw_fail_q ##0 run_led_q == error_led_q)
    else $error("failed upgrade pattern lost");
  AST_CARD_ALT: assert property (led_mode == DLER_M_CARD |=> run_led_q != error_led_q)
    else $error("card blink not alternate");
  AST_ACCESS: assert property (s_report(16'h002D) |=> flags_q.access_check_flag && log_q.valid)
    else $error("access check not flagged");
  AST_LATCHED: assert property (s_report(16'h0059) |=> flags_q.latched_memory_fault_flag && log_q.valid)
    else $error("latched memory not flagged");
  AST_CARD_FLAG: assert property (s_report(16'h0063) |=> flags_q.memory_card_flag && log_q.valid)
    else $error("memory card not flagged");
  AST_TIMEBASE: assert property (base_wrap |=> base_cnt_q == '0 ##0 $changed(tick_cnt_q))
    else $error("timebase did not advance");
  AST_FLAG_HOLD: assert property (flags_q.supply_fault_flag && !wr_flags |=> flags_q.supply_fault_flag)
    else $error("flag dropped without clear");

  // level faults, the upgrade strap and the range ends of the report codes
  AST_SUPPLY_PEND: assert property (sup_rise |=> pend_sup_q)
    else $error("supply rise not held pending");
  AST_RTC_REPORT: assert property (take_rtc |=> log_q.valid && log_q.code == 16'h0026
    && flags_q.clock_fault_flag)
    else $error("clock fault not reported");
  AST_BATT_STEADY: assert property (batt_shown && !rtc_fail |=> batt_led_q)
    else $error("battery light not steady");
  AST_REMOTE_LO: assert property (s_report(16'h1502) |=> flags_q.remote_module_fault_flag && log_q.valid)
    else $error("low remote error not flagged");
  AST_EXT_HI: assert property (s_report(16'h180F) |=> flags_q.extension_module_fault_flag
    && log_q.code == 16'h180F)
    else $error("high extension error not flagged");
  AST_BAD_ID: assert property (s_report(16'h0011) |=> flags_q.access_check_flag && log_q.valid)
    else $error("wrong identifier not flagged");
  AST_LAT_LO: assert property (s_report(16'h0050) |=> flags_q.latched_memory_fault_flag && log_q.valid)
    else $error("low latched memory code not flagged");
  AST_NO_CARD: assert property (s_report(16'h005D) |=> flags_q.memory_card_flag && log_q.valid)
    else $error("missing card not flagged");
  AST_UNKNOWN_IGNORED: assert property (fault_in.valid && !rep_valid |=> !log_q.valid)
    else $error("unknown code was logged");
  AST_FW_STRAP: assert property (!strap_done_q |=> fw_fail_q == $past(fw_upgrade_failed))
    else $error("upgrade strap not caught");
  AST_FW_CLEAR: assert property (fw_clr && strap_done_q |=> !fw_fail_q)
    else $error("upgrade failed state not cleared");
  AST_CARD_RUN: assert property (led_mode == DLER_M_CARD && half_ph |=> error_led_q && !run_led_q)
    else $error("card blink phase wrong");
  AST_IDLE_DARK: assert property (led_mode == DLER_M_NONE |=> !error_led_q)
    else $error("error light lit with no fault");

endmodule

`default_nettype wire

// >>> inc/dler_map.svh
/*
  constants of the diagnostic LED error reporter: timing, fault codes,
  register offsets, field positions and reset values.
  assumes a 250 MHz system clock and a 16-bit register port.
*/
`ifndef DLER_MAP_SVH
`define DLER_MAP_SVH

// clock and timebase
`define DLER_CLK_PERIOD_NS 4
`define DLER_TICK_TIME_MS 100
`define DLER_TICK_CYCLES ((`DLER_TICK_TIME_MS * 1000000) / `DLER_CLK_PERIOD_NS)
`define DLER_BASE_W 25
`define DLER_TICK_W 5

// blink figures, all whole multiples of one tick
`define DLER_FAST_PERIOD_MS 200
`define DLER_FAST_TICKS (`DLER_FAST_PERIOD_MS / 2 / `DLER_TICK_TIME_MS)
`define DLER_HALF_TIME_MS 500
`define DLER_HALF_TICKS (`DLER_HALF_TIME_MS / `DLER_TICK_TIME_MS)
`define DLER_SLOW_PERIOD_MS 3000
`define DLER_SLOW_TICKS (`DLER_SLOW_PERIOD_MS / `DLER_TICK_TIME_MS)
`define DLER_SLOW_ON_MS 1000
`define DLER_SLOW_ON_TICKS (`DLER_SLOW_ON_MS / `DLER_TICK_TIME_MS)

// fault codes
`define DLER_CODE_SUPPLY 16'h002A
`define DLER_CODE_REMOTE_LOST 16'h1500
`define DLER_CODE_REMOTE_LO 16'h1502
`define DLER_CODE_REMOTE_HI 16'h150F
`define DLER_CODE_EXT_LO 16'h1800
`define DLER_CODE_EXT_HI 16'h180F
`define DLER_CODE_HB_LO 16'h1900
`define DLER_CODE_HB_HI 16'h191C
`define DLER_CODE_BATT 16'h0027
`define DLER_CODE_RTC 16'h0026
`define DLER_CODE_BAD_ID 16'h0011
`define DLER_CODE_BAD_PW 16'h0012
`define DLER_CODE_PW_LIMIT 16'h002D
`define DLER_CODE_LAT_0 16'h0050
`define DLER_CODE_LAT_1 16'h0051
`define DLER_CODE_LAT_2 16'h0052
`define DLER_CODE_LAT_4 16'h0054
`define DLER_CODE_LAT_5 16'h0055
`define DLER_CODE_LAT_6 16'h0056
`define DLER_CODE_LAT_9 16'h0059
`define DLER_CODE_NO_CARD 16'h005D
`define DLER_CODE_CARD_INIT 16'h005E
`define DLER_CODE_CARD_WR 16'h0063

// register map
`define DLER_REG_CTRL 4'h0
`define DLER_REG_FLAGS 4'h1
`define DLER_REG_CODE 4'h2
`define DLER_REG_STATUS 4'h3
`define DLER_CTRL_BATT_SHOW_BIT 0
`define DLER_CTRL_FW_CLR_BIT 1
`define DLER_CTRL_BATT_SHOW_RST 1'b1
`define DLER_FLAGS_W 9

`endif

// >>> inc/dler_pkg.sv
/*
  types of the diagnostic LED error reporter.
  assumes dler_map.svh is on the include path.
*/
`default_nettype none
`include "dler_map.svh"

package dler_pkg;

  // fault report from firmware or peripheral logic
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } dler_fault_t;

  // error-log record, one-cycle valid
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } dler_log_t;

  // category flags, bit 0 is supply_fault_flag
  typedef struct packed {
    logic heartbeat_seen;
    logic memory_card_flag;
    logic latched_memory_fault_flag;
    logic access_check_flag;
    logic clock_fault_flag;
    logic battery_low_flag;
    logic extension_module_fault_flag;
    logic remote_module_fault_flag;
    logic supply_fault_flag;
  } dler_flags_t;

  typedef enum logic [2:0] {
    DLER_M_NONE,
    DLER_M_FW,
    DLER_M_CARD,
    DLER_M_SUPPLY,
    DLER_M_SLOW
  } dler_mode_t;

endpackage

`default_nettype wire

// >>> dv/dler_panel_model.sv
/*
  front-panel viewer model: measures how long the error and battery
  lamps stay lit in their last lit spell.
  assumes lamp outputs registered on ref_clk, reset synchronous active low.
*/
`timescale 1ns/1ps
`default_nettype none

module dler_panel_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic error_led,
  input wire logic battery_indicator_led,
  output logic [7:0] err_on_q,
  output logic [7:0] bat_on_q
);
  logic [7:0] err_run_q;
  logic [7:0] bat_run_q;

  // a viewer sees lit time only, so a lamp's spell length is kept at its fall
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_run_q <= 8'h00;
      bat_run_q <= 8'h00;
      err_on_q <= 8'h00;
      bat_on_q <= 8'h00;
    end else begin
      err_run_q <= error_led ? err_run_q + 8'h01 : 8'h00;
      bat_run_q <= battery_indicator_led ? bat_run_q + 8'h01 : 8'h00;
      if (!error_led && err_run_q != 8'h00) err_on_q <= err_run_q;
      if (!battery_indicator_led && bat_run_q != 8'h00) bat_on_q <= bat_run_q;
    end
  end
endmodule

`default_nettype wire

// >>> dv/tb_diagnostic_led_error_reporter.sv
/*
  self-checking bench of the diagnostic LED error reporter.
  assumes dler_pkg compiled first; timebase shortened to 4 cycles a tick.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_diagnostic_led_error_reporter;
  import dler_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic [15:0] reg_rdata;
  dler_fault_t fault_in = '0;
  logic supply_abnormal = 1'b0;
  logic battery_low = 1'b0;
  logic rtc_fail = 1'b0;
  logic fw_upgrade_active = 1'b0;
  logic fw_upgrade_failed = 1'b0;
  logic card_op_active = 1'b0;
  logic run_state = 1'b1;
  logic error_led, run_led, battery_indicator_led;
  dler_log_t log_rec;
  logic [15:0] err_code;
  dler_flags_t flags;
  logic [7:0] err_on, bat_on;
  logic [15:0] rd_val;
  int miscompares = 0;
  int comparisons = 0;
  int logs = 0;
  int err_hi, same;
  // last entry stays 0027 so the code register is known afterwards
  logic [15:0] codes [22] = '{16'h002A, 16'h1500, 16'h1502, 16'h150F, 16'h1800, 16'h180F, 16'h191C,
    16'h0026, 16'h0011, 16'h0012, 16'h002D, 16'h0050, 16'h0051, 16'h0052, 16'h0054, 16'h0055,
    16'h0056, 16'h0059, 16'h005D, 16'h005E, 16'h0063, 16'h0027};
  int fbit [22] = '{0, 1, 1, 1, 2, 2, 8, 4, 5, 5, 5, 6, 6, 6, 6, 6, 6, 6, 7, 7, 7, 3};

  always #2 ref_clk = ~ref_clk;

  // log pulses counted so silent reports can be proven silent
  always @(posedge ref_clk) if (log_rec.valid === 1'b1) logs <= logs + 1;

  dler_top #(.TICK_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
    .fault_in(fault_in), .supply_abnormal(supply_abnormal), .battery_low(battery_low),
    .rtc_fail(rtc_fail), .fw_upgrade_active(fw_upgrade_active), .fw_upgrade_failed(fw_upgrade_failed),
    .card_op_active(card_op_active), .run_state(run_state), .error_led(error_led), .run_led(run_led),
    .battery_indicator_led(battery_indicator_led), .log_rec(log_rec), .err_code(err_code), .flags(flags));

  dler_panel_model panel (.ref_clk(ref_clk), .rst_n(rst_n), .error_led(error_led),
    .battery_indicator_led(battery_indicator_led), .err_on_q(err_on), .bat_on_q(bat_on));

  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_stb <= 1'b1;
    @(posedge ref_clk);
    reg_wr_stb <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic send(input logic [15:0] code);
    @(posedge ref_clk);
    fault_in <= {1'b1, code};
    @(posedge ref_clk);
    fault_in <= '0;
    #1;
  endtask

  // level faults drain through a pending stage, so allow a few cycles
  task automatic wait_log(input logic [15:0] exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++) begin
      tick(1);
      if (log_rec.valid === 1'b1) seen = 1'b1;
    end
    chk("log valid", 16'h1, {15'h0, seen});
    chk("log code", exp, log_rec.code);
  endtask

  // sample lamp activity over n cycles
  task automatic watch(input int n);
    err_hi = 0;
    same = 0;
    repeat (n) begin
      tick(1);
      err_hi += (error_led === 1'b1);
      same += (error_led === run_led);
    end
  endtask

  task automatic t_reset;
    rd(4'h0);
    chk("ctrl reset", 16'h0001, rd_val);
    chk("flags reset", 16'h0000, {7'h0, flags});
    rd(4'h5);
    chk("unmapped read", 16'h0000, rd_val);
  endtask

  task automatic t_codes;
    int n;
    for (int i = 0; i < 22; i++) begin
      n = logs;
      send(codes[i]);
      chk("err code", codes[i], err_code);
      chk("flag set", 16'h1 << fbit[i], {7'h0, flags});
      tick(3);
      chk("log count", 16'(n + (codes[i] != 16'h0027)), 16'(logs));
      chk("flag sticky", 16'h1 << fbit[i], {7'h0, flags});
      wr(4'h1, 16'h01FF);
      chk("flag clear", 16'h0000, {7'h0, flags});
    end
    n = logs;
    send(16'h1501);
    send(16'h191D);
    wr(4'h2, 16'h1234);
    rd(4'h2);
    chk("code kept", 16'h0027, rd_val);
    chk("no log", 16'(n), 16'(logs));
  endtask

  task automatic t_supply;
    @(posedge ref_clk) supply_abnormal <= 1'b1;
    wait_log(16'h002A);
    chk("supply flag", 16'h0001, {7'h0, flags});
    watch(8);
    chk("fast on", 16'h4, 16'(err_hi));
    chk("run kept", 16'h1, {15'h0, run_led});
    rd(4'h3);
    chk("status supply", 16'h0001, rd_val >> 3);
    @(posedge ref_clk) supply_abnormal <= 1'b0;
    wr(4'h1, 16'h01FF);
  endtask

  task automatic t_slow;
    send(16'h1800);
    watch(130);
    watch(120);
    chk("slow on", 16'd40, 16'(err_hi));
    chk("slow spell", 16'd40, {8'h0, err_on});
    wr(4'h1, 16'h01FF);
    tick(3);
    chk("slow off", 16'h0, {15'h0, error_led});
  endtask

  task automatic t_battery;
    int n;
    n = logs;
    @(posedge ref_clk) battery_low <= 1'b1;
    tick(6);
    chk("batt flag", 16'h0008, {7'h0, flags});
    chk("batt code", 16'h0027, err_code);
    chk("batt led", 16'h1, {15'h0, battery_indicator_led});
    chk("batt no log", 16'(n), 16'(logs));
    wr(4'h0, 16'h0000);
    tick(3);
    chk("batt hidden", 16'h0, {15'h0, battery_indicator_led});
    wr(4'h0, 16'h0001);
    @(posedge ref_clk) battery_low <= 1'b0;
    wr(4'h1, 16'h01FF);
  endtask

  task automatic t_rtc;
    @(posedge ref_clk) rtc_fail <= 1'b1;
    wait_log(16'h0026);
    chk("rtc flag", 16'h0010, {7'h0, flags});
    tick(80);
    chk("rtc blink", 16'd20, {8'h0, bat_on});
    @(posedge ref_clk) rtc_fail <= 1'b0;
    wr(4'h1, 16'h01FF);
  endtask

  task automatic t_fw_card;
    @(posedge ref_clk) fw_upgrade_active <= 1'b1;
    tick(3);
    watch(40);
    chk("fw in phase", 16'd40, 16'(same));
    chk("fw on", 16'd20, 16'(err_hi));
    @(posedge ref_clk) begin
      fw_upgrade_active <= 1'b0;
      card_op_active <= 1'b1;
    end
    tick(3);
    watch(40);
    chk("card alternate", 16'd0, 16'(same));
    chk("card on", 16'd20, 16'(err_hi));
    @(posedge ref_clk) card_op_active <= 1'b0;
  endtask

  task automatic t_fw_fail;
    @(posedge ref_clk) begin
      rst_n <= 1'b0;
      fw_upgrade_failed <= 1'b1;
    end
    tick(2);
    @(posedge ref_clk) rst_n <= 1'b1;
    tick(2);
    @(posedge ref_clk) fw_upgrade_failed <= 1'b0;
    tick(3);
    watch(40);
    chk("failed fw phase", 16'd40, 16'(same));
    chk("failed fw on", 16'd20, 16'(err_hi));
    wr(4'h0, 16'h0003);
    tick(3);
    watch(8);
    chk("failed fw cleared", 16'd0, 16'(err_hi));
  endtask

  // a stuck handshake must not hang the run
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    tick(10);
    @(posedge ref_clk) rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_codes();
    t_supply();
    t_slow();
    t_battery();
    t_rtc();
    t_fw_card();
    t_fw_fail();
    wrap_up();
  end
endmodule

`default_nettype wire
